// ### design/sram_host_pkg.sv
// constants for the double-data-rate burst sram host controller
// assumes a 50 MHz system clock; the sram link clocks are divided from it
package sram_host_pkg;
    localparam int ADDR_W = 20;         // 1M 18-bit words, bursts of two at a and a^1
    localparam int WORD_W = 18;
    localparam int LANE_W = 2;
    localparam int BURST_W = 2 * WORD_W;
    localparam int BUF_DEPTH = 2;
    localparam int MCLK_NS = 20;
    // link clock divider: 8 system cycles per input timing clock period
    localparam logic [2:0] PH_LAST = 3'h7;
    localparam logic [2:0] PH_HALF = 3'h4;  // negative clock rises here
    localparam logic [2:0] PH_ISSUE = 3'h5; // pins change at phase 6
    localparam logic [2:0] PH_WORD2 = 3'h1; // second word changes at phase 2
    localparam logic [2:0] PH_DUE = 3'h2;   // arm capture after stale echo passes
    localparam int K_DIV = 8;
    // clock stop long enough to reset the delay loop
    localparam int STOP_NS = 30;
    localparam int STOP_CYC = (STOP_NS + MCLK_NS - 1) / MCLK_NS;
    localparam logic [1:0] STOP_LAST = 2'(STOP_CYC - 1);
    // delay loop lock time in input clock periods
    localparam int LOCK_KCYC = 1024;
    localparam logic [10:0] LOCK_LAST = 11'(LOCK_KCYC - 1);
    // idle cycles between a read and a following write
    localparam logic [1:0] RD_WR_NOPS = 2'h2;
    localparam int RD_WR_GAP = (2 + 1) * K_DIV;
    typedef enum logic [2:0] {
        ST_STOP = 3'b001,
        ST_LOCK = 3'b010,
        ST_RUN = 3'b100
    } link_state_t;
endpackage

// ### design/word_buffer.sv
// two-entry buffer for read bursts between the link and the user
// assumes one clock domain; pushes are only made while in_ready_o is high
`timescale 1ns/1ns
module word_buffer (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [sram_host_pkg::BURST_W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [sram_host_pkg::BURST_W-1:0] out_data_o,
    output logic [1:0] count_o
);
    import sram_host_pkg::*;

    logic [BURST_W-1:0] mem_r [BUF_DEPTH];
    logic [BURST_W-1:0] mem_nxt [BUF_DEPTH];
    logic wp_r, wp_nxt, rp_r, rp_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic push, pop;

    // honest full and empty straight from the occupancy count
    assign in_ready_o = (cnt_r != 2'(BUF_DEPTH));
    assign out_valid_o = (cnt_r != 2'h0);
    assign out_data_o = mem_r[rp_r];
    assign count_o = cnt_r;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // pointer and count next values
    always_comb begin
        wp_nxt = push ? ~wp_r : wp_r;
        rp_nxt = pop ? ~rp_r : rp_r;
        cnt_nxt = cnt_r + 2'(push) - 2'(pop);
    end

    // one write port per entry
    for (genvar e = 0; e < BUF_DEPTH; e++) begin : g_entry
        always_comb begin
            mem_nxt[e] = (push && wp_r == 1'(e)) ? in_data_i : mem_r[e];
        end
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                mem_r[e] <= '0;
            end else begin
                mem_r[e] <= mem_nxt[e];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ### design/ddr_burst_host.sv
// host controller driving a pipelined double-data-rate burst sram
// assumes the sram is wired to the pins below and echoes its output clocks
`timescale 1ns/1ns
module ddr_burst_host (
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic CMD_VALID_I,
    output logic CMD_READY_O,
    input wire logic CMD_WRITE_I,
    input wire logic [sram_host_pkg::ADDR_W-1:0] CMD_ADDR_I,
    input wire logic [sram_host_pkg::BURST_W-1:0] CMD_WDATA_I,
    input wire logic [2*sram_host_pkg::LANE_W-1:0] CMD_LANE_N_I,
    output logic RD_VALID_O,
    input wire logic RD_READY_I,
    output logic [sram_host_pkg::BURST_W-1:0] RD_DATA_O,
    input wire logic SINGLE_CLOCK_I,
    input wire logic LOOP_ENABLE_I,
    input wire logic LOOP_RESET_I,
    output logic LINK_READY_O,
    output logic K_O,
    output logic K_N_O,
    output logic C_O,
    output logic C_N_O,
    output logic [sram_host_pkg::ADDR_W-1:0] ADDR_O,
    output logic ACCESS_STROBE_N_O,
    output logic RW_O,
    output logic [sram_host_pkg::LANE_W-1:0] LANE_WRITE_SEL_N_O,
    input wire logic [sram_host_pkg::WORD_W-1:0] DQ_I,
    output logic [sram_host_pkg::WORD_W-1:0] DQ_O,
    output logic DQ_OE_O,
    input wire logic RETURN_STROBE_POS_I,
    input wire logic RETURN_STROBE_NEG_I,
    output logic LOOP_DISABLE_N_O
);
    import sram_host_pkg::*;

    localparam int SY_W = WORD_W + 2;

    // three-stage synchronisers for pins driven by the sram
    logic [SY_W-1:0] sy1_r, sy2_r, sy3_r;
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sy1_r <= '0;
            sy2_r <= '0;
            sy3_r <= '0;
        end else begin
            sy1_r <= {RETURN_STROBE_POS_I, RETURN_STROBE_NEG_I, DQ_I};
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
        end
    end

    // echo strobe filters: a change counts once stages two and three agree
    logic pos_f_r, pos_f_nxt, neg_f_r, neg_f_nxt, pos_rise, neg_rise;
    always_comb begin
        pos_f_nxt = (sy2_r[SY_W-1] == sy3_r[SY_W-1]) ? sy3_r[SY_W-1] : pos_f_r;
        neg_f_nxt = (sy2_r[SY_W-2] == sy3_r[SY_W-2]) ? sy3_r[SY_W-2] : neg_f_r;
        pos_rise = pos_f_nxt && !pos_f_r;
        neg_rise = neg_f_nxt && !neg_f_r;
    end
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pos_f_r <= 1'b0;
            neg_f_r <= 1'b0;
        end else begin
            pos_f_r <= pos_f_nxt;
            neg_f_r <= neg_f_nxt;
        end
    end

    link_state_t st_r, st_nxt;
    logic [2:0] ph_r, ph_nxt;
    logic [1:0] stop_cnt_r, stop_cnt_nxt;
    logic [10:0] lock_cnt_r, lock_cnt_nxt;
    logic strap_r, strap_nxt, strap_done_r;
    logic k_r, k_nxt, kn_r, kn_nxt, c_r, c_nxt, cn_r, cn_nxt, ldis_r, ldis_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic ld_n_r, ld_n_nxt, rw_r, rw_nxt;
    logic w1_v_r, w1_v_nxt, w2_v_r, w2_v_nxt;
    logic [BURST_W-1:0] wbuf_r, wbuf_nxt;
    logic [2*LANE_W-1:0] wlane_r, wlane_nxt;
    logic [WORD_W-1:0] w2_r, w2_nxt, dq_r, dq_nxt;
    logic [LANE_W-1:0] w2_lane_r, w2_lane_nxt, lane_r, lane_nxt;
    logic oe_r, oe_nxt;
    logic [1:0] nop_r, nop_nxt;
    logic rd_issue_r, rd_issue_nxt, rd_launch_r, rd_launch_nxt, rd_prev_r, rd_prev_nxt;
    logic [1:0] due1_r, due1_nxt, due2_r, due2_nxt, infl_r, infl_nxt;
    logic [WORD_W-1:0] cap_lo_r, cap_lo_nxt;
    logic push, buf_in_ready, busy, issue_slot, read_ok, write_ok, take;
    logic [1:0] buf_cnt;

    // issue gating: reads need a reserved buffer slot, writes need the gap
    always_comb begin
        busy = w1_v_r || w2_v_r || (infl_r != 2'h0) || rd_issue_r || rd_launch_r;
        issue_slot = (st_r == ST_RUN) && (ph_r == PH_ISSUE) && !LOOP_RESET_I;
        read_ok = buf_in_ready && ({1'b0, infl_r} + {1'b0, buf_cnt} < 3'(BUF_DEPTH));
        write_ok = (nop_r == 2'h0);
        CMD_READY_O = issue_slot && (CMD_WRITE_I ? write_ok : read_ok);
        take = CMD_READY_O && CMD_VALID_I;
        LINK_READY_O = (st_r == ST_RUN);
    end

    // link clocks, delay-loop sequencing and the single-clock strap
    always_comb begin
        st_nxt = st_r;
        stop_cnt_nxt = stop_cnt_r;
        lock_cnt_nxt = lock_cnt_r;
        ph_nxt = ph_r + 3'h1;
        strap_nxt = strap_done_r ? strap_r : SINGLE_CLOCK_I;
        ldis_nxt = LOOP_ENABLE_I;
        case (st_r)
            ST_STOP: begin
                // both input clocks held high long enough to reset the loop
                if (stop_cnt_r != STOP_LAST) begin
                    stop_cnt_nxt = stop_cnt_r + 2'h1;
                end else if (!LOOP_RESET_I) begin
                    st_nxt = ST_LOCK;
                    lock_cnt_nxt = 11'h000;
                end
                ph_nxt = 3'h0;
            end
            ST_LOCK: begin
                if (!LOOP_ENABLE_I) begin
                    st_nxt = ST_RUN;
                end else if (ph_r == PH_LAST) begin
                    if (lock_cnt_r == LOCK_LAST) begin
                        st_nxt = ST_RUN;
                    end
                    lock_cnt_nxt = lock_cnt_r + 11'h001;
                end
            end
            ST_RUN: begin
                // stop only when idle, so no started burst is cut short
                if (LOOP_RESET_I && !busy && ph_r == PH_LAST) begin
                    st_nxt = ST_STOP;
                    stop_cnt_nxt = 2'h0;
                end
            end
            default: begin
                st_nxt = ST_LOCK;
            end
        endcase
        if (st_nxt == ST_STOP) begin
            k_nxt = 1'b1;
            kn_nxt = 1'b1;
        end else begin
            k_nxt = (ph_nxt < PH_HALF);
            kn_nxt = !k_nxt;
        end
        c_nxt = strap_nxt ? 1'b1 : k_nxt;
        cn_nxt = strap_nxt ? 1'b1 : kn_nxt;
    end

    // command pins and write data; pins change a quarter input clock period from sampling edges
    always_comb begin
        addr_nxt = addr_r;
        ld_n_nxt = ld_n_r;
        rw_nxt = rw_r;
        w1_v_nxt = w1_v_r;
        w2_v_nxt = w2_v_r;
        wbuf_nxt = wbuf_r;
        wlane_nxt = wlane_r;
        w2_nxt = w2_r;
        w2_lane_nxt = w2_lane_r;
        dq_nxt = dq_r;
        lane_nxt = lane_r;
        oe_nxt = oe_r;
        nop_nxt = nop_r;
        if (ph_r == PH_ISSUE) begin
            ld_n_nxt = 1'b1;
            if (nop_r != 2'h0) begin
                nop_nxt = nop_r - 2'h1;
            end
            // first word of the write launched at the last rise
            if (w1_v_r) begin
                dq_nxt = wbuf_r[WORD_W-1:0];
                lane_nxt = wlane_r[LANE_W-1:0];
                oe_nxt = 1'b1;
                w2_nxt = wbuf_r[BURST_W-1:WORD_W];
                w2_lane_nxt = wlane_r[2*LANE_W-1:LANE_W];
            end else begin
                oe_nxt = 1'b0;
                lane_nxt = {LANE_W{1'b1}};
            end
            w2_v_nxt = w1_v_r;
            w1_v_nxt = 1'b0;
            if (take) begin
                addr_nxt = CMD_ADDR_I;
                ld_n_nxt = 1'b0;
                rw_nxt = !CMD_WRITE_I;
                if (CMD_WRITE_I) begin
                    w1_v_nxt = 1'b1;
                    wbuf_nxt = CMD_WDATA_I;
                    wlane_nxt = CMD_LANE_N_I;
                end else begin
                    nop_nxt = RD_WR_NOPS;
                end
            end
        end
        // second word, held across the negative clock rise
        if (ph_r == PH_WORD2 && w2_v_r) begin
            dq_nxt = w2_r;
            lane_nxt = w2_lane_r;
            w2_v_nxt = 1'b0;
        end
    end

    // read return: words are taken on echo edges once a burst is due
    always_comb begin
        rd_issue_nxt = rd_issue_r;
        rd_launch_nxt = rd_launch_r;
        rd_prev_nxt = rd_prev_r;
        due1_nxt = due1_r;
        due2_nxt = due2_r;
        infl_nxt = infl_r;
        cap_lo_nxt = cap_lo_r;
        push = 1'b0;
        if (take && !CMD_WRITE_I) begin
            rd_issue_nxt = 1'b1;
        end
        if (ph_r == PH_LAST) begin
            rd_launch_nxt = rd_issue_r;
            rd_prev_nxt = rd_launch_r;
            rd_issue_nxt = 1'b0;
        end
        // arming late skips the echo edge left over from the last cycle
        if (ph_r == PH_DUE && rd_prev_r) begin
            due1_nxt = due1_nxt + 2'h1;
        end
        if (neg_rise && due1_r != 2'h0) begin
            cap_lo_nxt = sy3_r[WORD_W-1:0];
            due1_nxt = due1_nxt - 2'h1;
            due2_nxt = due2_nxt + 2'h1;
        end
        if (pos_rise && due2_r != 2'h0) begin
            push = 1'b1;
            due2_nxt = due2_nxt - 2'h1;
            infl_nxt = infl_nxt - 2'h1;
        end
        if (take && !CMD_WRITE_I) begin
            infl_nxt = infl_nxt + 2'h1;
        end
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st_r <= ST_LOCK;
            ph_r <= 3'h0;
            stop_cnt_r <= 2'h0;
            lock_cnt_r <= 11'h000;
            strap_r <= 1'b0;
            strap_done_r <= 1'b0;
            k_r <= 1'b0;
            kn_r <= 1'b1;
            c_r <= 1'b0;
            cn_r <= 1'b1;
            ldis_r <= 1'b0;
            addr_r <= '0;
            ld_n_r <= 1'b1;
            rw_r <= 1'b1;
            w1_v_r <= 1'b0;
            w2_v_r <= 1'b0;
            wbuf_r <= '0;
            wlane_r <= '1;
            w2_r <= '0;
            w2_lane_r <= '1;
            dq_r <= '0;
            lane_r <= '1;
            oe_r <= 1'b0;
            nop_r <= 2'h0;
            rd_issue_r <= 1'b0;
            rd_launch_r <= 1'b0;
            rd_prev_r <= 1'b0;
            due1_r <= 2'h0;
            due2_r <= 2'h0;
            infl_r <= 2'h0;
            cap_lo_r <= '0;
        end else begin
            st_r <= st_nxt;
            ph_r <= ph_nxt;
            stop_cnt_r <= stop_cnt_nxt;
            lock_cnt_r <= lock_cnt_nxt;
            strap_r <= strap_nxt;
            strap_done_r <= 1'b1;
            k_r <= k_nxt;
            kn_r <= kn_nxt;
            c_r <= c_nxt;
            cn_r <= cn_nxt;
            ldis_r <= ldis_nxt;
            addr_r <= addr_nxt;
            ld_n_r <= ld_n_nxt;
            rw_r <= rw_nxt;
            w1_v_r <= w1_v_nxt;
            w2_v_r <= w2_v_nxt;
            wbuf_r <= wbuf_nxt;
            wlane_r <= wlane_nxt;
            w2_r <= w2_nxt;
            w2_lane_r <= w2_lane_nxt;
            dq_r <= dq_nxt;
            lane_r <= lane_nxt;
            oe_r <= oe_nxt;
            nop_r <= nop_nxt;
            rd_issue_r <= rd_issue_nxt;
            rd_launch_r <= rd_launch_nxt;
            rd_prev_r <= rd_prev_nxt;
            due1_r <= due1_nxt;
            due2_r <= due2_nxt;
            infl_r <= infl_nxt;
            cap_lo_r <= cap_lo_nxt;
        end
    end

    assign K_O = k_r;
    assign K_N_O = kn_r;
    assign C_O = c_r;
    assign C_N_O = cn_r;
    assign LOOP_DISABLE_N_O = ldis_r;
    assign ADDR_O = addr_r;
    assign ACCESS_STROBE_N_O = ld_n_r;
    assign RW_O = rw_r;
    assign LANE_WRITE_SEL_N_O = lane_r;
    assign DQ_O = dq_r;
    assign DQ_OE_O = oe_r;

    // reserved slots keep the buffer from ever refusing a finished burst
    word_buffer u_rdbuf (
        .clk_i(MCLK_I),
        .rstn_i(RSTN_I),
        .in_valid_i(push),
        .in_ready_o(buf_in_ready),
        .in_data_i({sy3_r[WORD_W-1:0], cap_lo_r}),
        .out_valid_o(RD_VALID_O),
        .out_ready_i(RD_READY_I),
        .out_data_o(RD_DATA_O),
        .count_o(buf_cnt)
    );

    // helpers for the checks below
    logic [WORD_W-1:0] wd_lo, wd_hi;
    logic [LANE_W-1:0] wl_lo, wl_hi;
    logic [7:0] since_rd_r;
    assign wd_lo = CMD_WDATA_I[WORD_W-1:0];
    assign wd_hi = CMD_WDATA_I[BURST_W-1:WORD_W];
    assign wl_lo = CMD_LANE_N_I[LANE_W-1:0];
    assign wl_hi = CMD_LANE_N_I[2*LANE_W-1:LANE_W];
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            since_rd_r <= 8'hff;
        end else if (take && !CMD_WRITE_I) begin
            since_rd_r <= 8'h01;
        end else if (since_rd_r != 8'hff) begin
            since_rd_r <= since_rd_r + 8'h01;
        end
    end

    sequence s_word1;
        ##9 (DQ_OE_O && DQ_O == $past(wd_lo, 9) && LANE_WRITE_SEL_N_O == $past(wl_lo, 9));
    endsequence
    sequence s_word2;
        ##4 (DQ_OE_O && DQ_O == $past(wd_hi, 13) && LANE_WRITE_SEL_N_O == $past(wl_hi, 13));
    endsequence

    property p_read_req;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        take && !CMD_WRITE_I |=> !ACCESS_STROBE_N_O && RW_O && ADDR_O == $past(CMD_ADDR_I);
    endproperty
    a_read_req: assert property (p_read_req) else $error("read request pins wrong");
    property p_write_req;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        take && CMD_WRITE_I |=> !ACCESS_STROBE_N_O && !RW_O && ADDR_O == $past(CMD_ADDR_I);
    endproperty
    a_write_req: assert property (p_write_req) else $error("write request pins wrong");
    property p_write_words;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        take && CMD_WRITE_I |-> s_word1 ##0 s_word2;
    endproperty
    a_write_words: assert property (p_write_words) else $error("write words misplaced");
    property p_lane_hold;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        DQ_OE_O && $changed(LANE_WRITE_SEL_N_O)
            |-> $past(ph_r == PH_ISSUE) || $past(ph_r == PH_WORD2);
    endproperty
    a_lane_hold: assert property (p_lane_hold) else $error("lane changed mid word");
    property p_rd_wr_gap;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        take && CMD_WRITE_I |-> since_rd_r >= 8'(RD_WR_GAP);
    endproperty
    a_rd_wr_gap: assert property (p_rd_wr_gap) else $error("write too soon after read");
    property p_clock_stop;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        $rose(st_r == ST_STOP) |-> (K_O && K_N_O)[*2];
    endproperty
    a_clock_stop: assert property (p_clock_stop) else $error("clock stop too short");
    property p_strap;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        strap_r |=> C_O && C_N_O && $stable(strap_r);
    endproperty
    a_strap: assert property (p_strap) else $error("single-clock strap broken");
    property p_issue_slot;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        take |-> ph_r == PH_ISSUE ##1 K_O == 1'b0 ##2 K_O;
    endproperty
    a_issue_slot: assert property (p_issue_slot) else $error("issue off the clock slot");
    property p_strobe_cause;
        @(posedge MCLK_I) disable iff (!RSTN_I)
        $fell(ACCESS_STROBE_N_O) |-> $past(take);
    endproperty
    a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without command");
endmodule

// ### testbench/sram_model.sv
// behavioural burst sram answering the host controller's pins
// assumes the host makes all link clocks; data bus split in and out
`timescale 1ns/1ns
module sram_model (
    input wire logic k_i,
    input wire logic kn_i,
    input wire logic c_i,
    input wire logic cn_i,
    input wire logic [19:0] addr_i,
    input wire logic ld_n_i,
    input wire logic rw_i,
    input wire logic [1:0] lane_n_i,
    input wire logic [17:0] d_i,
    output logic [17:0] q_o,
    output logic cq_o,
    output logic cqn_o
);
    logic [17:0] mem [int];
    logic [17:0] q = 18'h0;
    logic drv = 1'b0;
    logic single = 1'b0;
    int cal_cnt = 0;
    int owner = 0;
    int seq = 0;
    // a released bus shows the inverse so a stale word never passes
    assign q_o = drv ? q : ~q;
    // echoes follow the output pair, or the input pair when strapped
    assign cq_o = single ? k_i : c_i;
    assign cqn_o = single ? kn_i : cn_i;
    function automatic logic [17:0] rdw(input logic [19:0] a);
        return mem.exists(a) ? mem[a] : 18'h0;
    endfunction
    // store is immediate, so a read always sees the newest write
    task automatic put(input logic [19:0] a, input logic [1:0] l);
        logic [17:0] o;
        o = rdw(a);
        if (!l[0]) o[8:0] = d_i[8:0];
        if (!l[1]) o[17:9] = d_i[17:9];
        mem[a] = o;
    endtask
    task automatic wr(input logic [19:0] a);
        @(posedge k_i) put(a, lane_n_i);
        @(posedge kn_i) put(a ^ 20'h1, lane_n_i);
    endtask
    task automatic rd(input logic [19:0] a);
        int id;
        id = ++seq;
        @(posedge k_i);
        @(posedge (single ? kn_i : cn_i));
        q = rdw(a);
        drv = 1'b1;
        owner = id;
        @(posedge (single ? k_i : c_i));
        q = rdw(a ^ 20'h1);
        @(posedge (single ? kn_i : cn_i));
        if (owner == id) drv = 1'b0;
    endtask
    // accesses start only at a positive input rise with the strobe low
    always @(posedge k_i) begin
        // strap re-read on each rise; the host only changes it across a reset
        single = c_i && cn_i;
        cal_cnt = (cal_cnt + 1) % 1024; // impedance retune point, no logic effect
        if (!ld_n_i && rw_i) fork rd(addr_i); join_none
        if (!ld_n_i && !rw_i) fork wr(addr_i); join_none
    end
endmodule

// ### testbench/testbench.sv
// self-checking bench for the burst sram host with a model sram
// assumes loop enable low, except in the relock scenario that waits for lock
`timescale 1ns/1ns
module testbench;
    import sram_host_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0;
    logic rd_ready = 1'b0, loop_rst = 1'b0, loop_en = 1'b0, strap = 1'b0, loop_dis_n;
    logic [19:0] cmd_addr = 20'h0, addr;
    logic [35:0] cmd_wdata = 36'h0, rd_data;
    logic [3:0] cmd_lane_n = 4'hf;
    logic [1:0] lanes;
    logic [17:0] dq_i, dq_o;
    logic cmd_ready, rd_valid, link_ready, k, kn, c, cn, strobe_n, rw, dq_oe, cq, cqn;
    int err_count = 0, tests_run = 0;
    time t_take, t0;
    ddr_burst_host uut (.MCLK_I(clk), .RSTN_I(rstn), .CMD_VALID_I(cmd_valid),
        .CMD_READY_O(cmd_ready), .CMD_WRITE_I(cmd_write), .CMD_ADDR_I(cmd_addr),
        .CMD_WDATA_I(cmd_wdata), .CMD_LANE_N_I(cmd_lane_n), .RD_VALID_O(rd_valid),
        .RD_READY_I(rd_ready), .RD_DATA_O(rd_data), .SINGLE_CLOCK_I(strap),
        .LOOP_ENABLE_I(loop_en), .LOOP_RESET_I(loop_rst), .LINK_READY_O(link_ready),
        .K_O(k), .K_N_O(kn), .C_O(c), .C_N_O(cn), .ADDR_O(addr),
        .ACCESS_STROBE_N_O(strobe_n), .RW_O(rw), .LANE_WRITE_SEL_N_O(lanes),
        .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE_O(dq_oe), .RETURN_STROBE_POS_I(cq),
        .RETURN_STROBE_NEG_I(cqn), .LOOP_DISABLE_N_O(loop_dis_n));
    sram_model mem0 (.k_i(k), .kn_i(kn), .c_i(c), .cn_i(cn), .addr_i(addr),
        .ld_n_i(strobe_n), .rw_i(rw), .lane_n_i(lanes), .d_i(dq_o), .q_o(dq_i),
        .cq_o(cq), .cqn_o(cqn));
    // system clock, 20 ns period
    initial forever #10 clk = ~clk;
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        tests_run++;
        if (g !== e) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            err_count++;
        end
    endtask
    // offer one command and hold it until the edge that takes it
    task automatic cmd(input logic w, input logic [19:0] a, input logic [35:0] d,
        input logic [3:0] l);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_lane_n <= l;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        t_take = $time;
        cmd_valid <= 1'b0;
        chk(36'(n < 400), 36'h1);
    endtask
    // wait for a read burst, compare, then pop it
    task automatic get(input logic [35:0] e);
        int n;
        n = 0;
        @(negedge clk);
        while (rd_valid !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk(rd_data, e);
        @(posedge clk);
        rd_ready <= 1'b1;
        @(posedge clk);
        rd_ready <= 1'b0;
    endtask
    task automatic t_idle;
        @(negedge clk);
        chk(36'({strobe_n, dq_oe, link_ready, loop_dis_n}), 36'ha);
    endtask
    task automatic t_write_read;
        cmd(1'b1, 20'h00010, {18'h15a5a, 18'h2a5a5}, 4'h0);
        cmd(1'b0, 20'h00010, 36'h0, 4'hf);
        get({18'h15a5a, 18'h2a5a5});
    endtask
    task automatic t_lanes;
        cmd(1'b1, 20'h00010, {18'h3ffff, 18'h3ffff}, 4'b0110);
        cmd(1'b0, 20'h00010, 36'h0, 4'hf);
        get({18'h3fe5a, 18'h2a5ff});
    endtask
    // odd seed swaps the burst order; a write right after a read must wait
    task automatic t_odd_gap;
        cmd(1'b1, 20'h00021, {18'h0beef, 18'h1cafe}, 4'h0);
        cmd(1'b0, 20'h00020, 36'h0, 4'hf);
        t0 = t_take;
        cmd(1'b1, 20'h00030, {18'h00001, 18'h00002}, 4'h0);
        chk(36'((t_take - t0) >= RD_WR_GAP * MCLK_NS), 36'h1);
        get({18'h1cafe, 18'h0beef});
        cmd(1'b0, 20'h00030, 36'h0, 4'hf);
        get({18'h00001, 18'h00002});
    endtask
    // back-to-back reads held in the buffer while the user stalls
    task automatic t_stall;
        cmd(1'b0, 20'h00010, 36'h0, 4'hf);
        cmd(1'b0, 20'h00020, 36'h0, 4'hf);
        repeat (100) @(posedge clk);
        get({18'h3fe5a, 18'h2a5ff});
        get({18'h1cafe, 18'h0beef});
    endtask
    // clock stop, then relock with the delay loop enabled
    task automatic t_loop;
        loop_rst <= 1'b1;
        loop_en <= 1'b1;
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk(36'({k, kn, link_ready, loop_dis_n}), 36'hd);
        @(posedge clk);
        loop_rst <= 1'b0;
        repeat (LOCK_KCYC * K_DIV - 64) @(posedge clk);
        @(negedge clk);
        chk(36'(link_ready), 36'h0);
        cmd(1'b0, 20'h00021, 36'h0, 4'hf);
        get({18'h0beef, 18'h1cafe});
    endtask
    // mid-run reset into single-clock mode, then back-to-back writes and reads
    task automatic t_single;
        rstn <= 1'b0;
        strap <= 1'b1;
        loop_en <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(36'({c, cn, link_ready}), 36'h7);
        cmd(1'b1, 20'h00040, {18'h00444, 18'h00333}, 4'h0);
        cmd(1'b1, 20'h00050, {18'h00666, 18'h00555}, 4'h0);
        cmd(1'b0, 20'h00040, 36'h0, 4'hf);
        cmd(1'b0, 20'h00050, 36'h0, 4'hf);
        get({18'h00444, 18'h00333});
        get({18'h00666, 18'h00555});
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_idle();
        t_write_read();
        t_lanes();
        t_odd_gap();
        t_stall();
        t_loop();
        t_single();
        close_out();
    end
    // cut a hang short well past the nine thousand or so cycles, mostly relock
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        close_out();
    end
endmodule
